// ==== serial_flash_cmd.sv ====
`timescale 1ns/10ps
`include "flash_cmd_params.svh"
// How it works
// - latch-set opcode sets write latch
// - latch-set shifted on rising link edges
// - volatile enable arms status write only
// - latch-clear drops latch and volatile arm
// - latch auto-clears at reset, completions
// - status bytes shift out msb first
// - status readable anytime, repeats until deselect
// - only writable status bits change
// - security lock bits never clear
// - non-volatile write needs latch set
// - volatile write keeps latch, lock1 sticky
// - status write needs exactly 8/16 bits
// - short write clears complement, four-line
// - non-volatile write timed busy, latch clears
// - volatile write applies quickly, busy low
// - status bits reset to zero
// - array read: 24-bit address, byte out
// - read address increments, streams on
// - array read ignored while busy
// - id read: three dummies, id repeats
// - dual id: two-lane address, alternating ids
// - quad id: four dummies, ids repeat
// - writes act only on byte boundary
// - busy ignores all but status reads
module serial_flash_cmd #(
  parameter int         STAT_WRITE_TIME_NS = `STAT_WRITE_TIME_NS,
  parameter int         BUF_WIDTH          = 8,
  parameter int         BUF_DEPTH          = 2,
  parameter logic [7:0] MANUF_ID           = 8'ha5, // arbitrary value
  parameter logic [7:0] DEVICE_ID          = 8'h3c  // arbitrary value
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   cs_n_pin,
  input  wire logic                   sclk_pin,
  input  wire logic [3:0]             io_in,
  output logic [3:0]                  io_out,
  output logic [3:0]                  io_oe_n,
  input  wire logic                   ext_cycle_busy,
  input  wire logic                   ext_cycle_done,
  input  wire logic                   suspended_in,
  output logic                        req_valid,
  input  wire logic                   req_ready,
  output logic [23:0]                 req_addr,
  input  wire logic                   mem_valid,
  output logic                        mem_ready,
  input  wire logic [BUF_WIDTH-1:0]   mem_data,
  output flash_cmd_pkg::status_s      status
);
  import flash_cmd_pkg::*;

  localparam int NV_RAW = STAT_WRITE_TIME_NS / `CORE_PERIOD_NS;
  localparam int NV_CYC = (NV_RAW < 1) ? 1 : NV_RAW;
  localparam int VO_RAW = `VOL_REFRESH_NS / `CORE_PERIOD_NS;
  localparam int VO_CYC = (VO_RAW < 1) ? 1 : VO_RAW;
  localparam int AW     = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  logic [5:0]  pin_raw;
  logic [5:0]  pin_f;
  logic        cs_f;
  logic        ck_f;
  logic [3:0]  io_f;
  logic        cs_q;
  logic        ck_q;
  logic        rise;
  logic        fall;
  logic        cs_rise;
  phase_e      state;
  logic [7:0]  cmd;
  logic [4:0]  clk_cnt;
  logic [31:0] sh_in;
  logic [31:0] next_sh;
  lanes_t      lanes;
  logic [4:0]  addr_len;
  logic [7:0]  dec_cmd;
  phase_e      dec_phase;
  logic        id_sel;
  logic        id_tog;
  logic [23:0] start_addr;
  logic        rd_start;
  logic [7:0]  out_sh;
  logic [3:0]  out_left;
  logic [7:0]  next_byte;
  logic [7:0]  cur_byte;
  logic        pop;
  logic        busy;
  logic [15:0] stat_word;
  logic                 rd_active;
  logic [23:0]          rd_addr;
  logic [AW:0]          outst;
  logic [AW:0]          buf_cnt;
  logic [AW-1:0]        wr_ptr;
  logic [AW-1:0]        rd_ptr;
  logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
  logic                 req_fire;
  logic                 ans_fire;
  logic                 push;

  // pin synchronisers, a change counts when stages two and three agree
  assign pin_raw = {cs_n_pin, sclk_pin, io_in};
  for (genvar g = 0; g < 6; g++) begin : g_sync
    logic [2:0] s;
    logic       filt;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        s    <= (g == 5) ? 3'b111 : 3'b000;
        filt <= (g == 5) ? 1'b1 : 1'b0;
      end else begin
        s <= {s[1:0], pin_raw[g]};
        if (s[1] == s[2]) begin
          filt <= s[2];
        end
      end
    end
    assign pin_f[g] = filt;
  end

  assign cs_f = pin_f[5];
  assign ck_f = pin_f[4];
  assign io_f = pin_f[3:0];

  // link clock and select edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= 1'b1;
      ck_q <= 1'b0;
    end else begin
      cs_q <= cs_f;
      ck_q <= ck_f;
    end
  end

  assign rise    = ck_f & ~ck_q & ~cs_f;
  assign fall    = ~ck_f & ck_q & ~cs_f;
  assign cs_rise = cs_f & ~cs_q;

  // lane count and input shift for the current phase
  always_comb begin
    lanes = 3'd1;
    if (state == ST_DUMMY ||
        ((state == ST_ADDR || state == ST_OUT) && cmd == `OP_ID4_RD)) begin
      lanes = 3'd4;
    end else if ((state == ST_ADDR || state == ST_OUT) &&
                 cmd == `OP_ID2_RD) begin
      lanes = 3'd2;
    end
    case (lanes)
      3'd2:    next_sh = {sh_in[29:0], io_f[1:0]};
      3'd4:    next_sh = {sh_in[27:0], io_f};
      default: next_sh = {sh_in[30:0], io_f[0]};
    endcase
  end

  // address phase length per instruction
  always_comb begin
    case (cmd)
      `OP_ID2_RD: addr_len = `ADDR_CLKS_2;
      `OP_ID4_RD: addr_len = `ADDR_CLKS_4;
      default:    addr_len = `ADDR_CLKS_1;
    endcase
  end

  // opcode decode, busy blocks all but status reads
  always_comb begin
    dec_cmd   = next_sh[7:0];
    dec_phase = ST_SKIP;
    if (busy && dec_cmd != `OP_STAT1_RD && dec_cmd != `OP_STAT2_RD) begin
      dec_cmd = 8'h00;
    end
    case (dec_cmd)
      `OP_STAT1_RD, `OP_STAT2_RD: dec_phase = ST_OUT;
      `OP_STAT_WR:                dec_phase = ST_WDATA;
      `OP_ARRAY_RD, `OP_ID_RD,
      `OP_ID2_RD, `OP_ID4_RD:     dec_phase = ST_ADDR;
      default:                    dec_phase = ST_SKIP;
    endcase
  end

  // instruction sequencer, sampled on rising link edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_OPCODE;
      cmd        <= 8'h00;
      clk_cnt    <= 5'd0;
      sh_in      <= 32'h00000000;
      id_sel     <= 1'b0;
      start_addr <= 24'h000000;
      rd_start   <= 1'b0;
    end else begin
      rd_start <= 1'b0;
      if (cs_f) begin
        state   <= ST_OPCODE;
        clk_cnt <= 5'd0;
      end else if (rise) begin
        sh_in   <= next_sh;
        clk_cnt <= (clk_cnt == 5'd31) ? clk_cnt : clk_cnt + 5'd1;
        case (state)
          ST_OPCODE: begin
            if (clk_cnt == 5'd7) begin
              cmd     <= dec_cmd;
              state   <= dec_phase;
              clk_cnt <= 5'd0;
            end
          end
          ST_ADDR: begin
            if (clk_cnt == addr_len - 5'd1) begin
              clk_cnt    <= 5'd0;
              state      <= (cmd == `OP_ID4_RD) ? ST_DUMMY : ST_OUT;
              id_sel     <= (cmd == `OP_ID_RD) ? 1'b0 : next_sh[8];
              start_addr <= next_sh[23:0];
              rd_start   <= (cmd == `OP_ARRAY_RD);
            end
          end
          ST_DUMMY: begin
            if (clk_cnt == `DUMMY_CLKS_4 - 5'd1) begin
              clk_cnt <= 5'd0;
              state   <= ST_OUT;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // next byte to send, status reloaded live on every byte
  always_comb begin
    case (cmd)
      `OP_STAT1_RD: next_byte = stat_word[7:0];
      `OP_STAT2_RD: next_byte = stat_word[15:8];
      `OP_ID_RD:    next_byte = DEVICE_ID;
      `OP_ID2_RD,
      `OP_ID4_RD:   next_byte = (id_sel ^ id_tog) ? DEVICE_ID : MANUF_ID;
      default:      next_byte = 8'hff;
    endcase
    if (cmd == `OP_ARRAY_RD) begin
      next_byte = (buf_cnt != '0) ? 8'(buf_mem[rd_ptr]) : 8'hff;
    end
    cur_byte = (out_left == 4'd0) ? next_byte : out_sh;
  end

  assign pop = fall & (state == ST_OUT) & (out_left == 4'd0) &
               (cmd == `OP_ARRAY_RD) & (buf_cnt != '0);

  // output shifter, driven on falling link edges, msb first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh   <= 8'h00;
      out_left <= 4'd0;
      io_out   <= 4'h0;
      io_oe_n  <= 4'hf;
      id_tog   <= 1'b0;
    end else if (cs_f) begin
      out_left <= 4'd0;
      io_oe_n  <= 4'hf;
      id_tog   <= 1'b0;
    end else if (fall && state == ST_OUT) begin
      case (lanes)
        3'd4: begin
          io_out  <= cur_byte[7:4];
          io_oe_n <= 4'h0;
          out_sh  <= {cur_byte[3:0], 4'h0};
        end
        3'd2: begin
          io_out  <= {2'b00, cur_byte[7:6]};
          io_oe_n <= 4'hc;
          out_sh  <= {cur_byte[5:0], 2'b00};
        end
        default: begin
          io_out  <= {2'b00, cur_byte[7], 1'b0};
          io_oe_n <= 4'hd;
          out_sh  <= {cur_byte[6:0], 1'b0};
        end
      endcase
      out_left <= ((out_left == 4'd0) ? 4'd8 : out_left) - 4'(lanes);
      if (out_left == 4'd0 &&
          (cmd == `OP_ID2_RD || cmd == `OP_ID4_RD)) begin
        id_tog <= ~id_tog;
      end
    end
  end

  // array fetch and two-entry read buffer
  assign req_valid = rd_active &&
                     (int'(outst) + int'(buf_cnt) < BUF_DEPTH);
  assign mem_ready = ~rd_active | (int'(buf_cnt) < BUF_DEPTH);
  assign req_addr  = rd_addr;
  assign req_fire  = req_valid & req_ready;
  assign ans_fire  = mem_valid & mem_ready;
  assign push      = ans_fire & rd_active;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_active <= 1'b0;
      rd_addr   <= 24'h000000;
      buf_cnt   <= '0;
      wr_ptr    <= '0;
      rd_ptr    <= '0;
    end else if (cs_f) begin
      rd_active <= 1'b0;
      buf_cnt   <= '0;
      wr_ptr    <= '0;
      rd_ptr    <= '0;
    end else begin
      if (rd_start) begin
        rd_active <= 1'b1;
        rd_addr   <= start_addr;
      end else if (req_fire) begin
        rd_addr <= rd_addr + 24'd1;
      end
      if (push) begin
        wr_ptr <= (int'(wr_ptr) == BUF_DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (int'(rd_ptr) == BUF_DEPTH - 1) ? '0 : rd_ptr + 1'b1;
      end
      buf_cnt <= buf_cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // buffer storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_mem[wr_ptr] <= mem_data;
    end
  end

  // answers still owed by the array side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outst <= '0;
    end else begin
      outst <= outst + (AW+1)'(req_fire) - (AW+1)'(ans_fire);
    end
  end

  // status register write path
  logic [15:0] sr;
  logic        write_latch_flag;
  logic        vol_en;
  logic        nv_busy;
  logic [31:0] nv_cnt;
  logic [7:0]  vol_cnt;
  logic [15:0] pend;
  logic        ev_set;
  logic        ev_vol;
  logic        ev_clr;
  logic        wr_end;
  logic        wr_long;
  logic [15:0] wr_word;
  logic        nv_go;
  logic        vol_go;
  logic        nv_done;

  function automatic logic [15:0] merge_status(input logic [15:0] old,
      input logic [15:0] wr, input logic long_wr, input logic vol);
    logic [15:0] n;
    n = (old & ~`STAT_WR_MASK) | (wr & `STAT_WR_MASK);
    if (!long_wr) begin
      n[`POS_FOUR_LINE] = 1'b0;
      n[`POS_PROT_COMP] = 1'b0;
    end
    n[13:11] = n[13:11] | old[13:11];
    if (vol) begin
      n[`POS_LOCK1] = n[`POS_LOCK1] | old[`POS_LOCK1];
    end
    return n;
  endfunction

  // one-byte commands act only after exactly eight clocks
  assign ev_set  = cs_rise && state == ST_SKIP && clk_cnt == 5'd0 &&
                   cmd == `OP_LATCH_SET;
  assign ev_vol  = cs_rise && state == ST_SKIP && clk_cnt == 5'd0 &&
                   cmd == `OP_VOL_ENABLE;
  assign ev_clr  = cs_rise && state == ST_SKIP && clk_cnt == 5'd0 &&
                   cmd == `OP_LATCH_CLR;
  assign wr_end  = cs_rise && state == ST_WDATA &&
                   (clk_cnt == `WR_SHORT || clk_cnt == `WR_LONG);
  assign wr_long = (clk_cnt == `WR_LONG);
  assign wr_word = wr_long ? {sh_in[7:0], sh_in[15:8]} // first byte is sr1
                           : {sr[15:8], sh_in[7:0]};
  assign nv_go   = wr_end & write_latch_flag;
  assign vol_go  = wr_end & ~write_latch_flag & vol_en;
  assign nv_done = nv_busy && nv_cnt == 32'd1;

  // write latch flag, set wins over a same-cycle clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_latch_flag <= 1'b0;
    end else begin
      if (nv_done || ext_cycle_done || ev_clr) begin
        write_latch_flag <= 1'b0;
      end
      if (ev_set) begin
        write_latch_flag <= 1'b1;
      end
    end
  end

  // volatile write arm, consumed by the next status write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vol_en <= 1'b0;
    end else begin
      if (ev_clr || wr_end) begin
        vol_en <= 1'b0;
      end
      if (ev_vol) begin
        vol_en <= 1'b1;
      end
    end
  end

  // self-timed non-volatile cycle and short volatile refresh
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_busy <= 1'b0;
      nv_cnt  <= 32'd0;
      vol_cnt <= 8'd0;
      pend    <= `STAT_RESET;
    end else begin
      if (nv_go) begin
        nv_busy <= 1'b1;
        nv_cnt  <= 32'(NV_CYC);
        pend    <= merge_status(sr, wr_word, wr_long, 1'b0);
      end else if (nv_busy) begin
        nv_cnt <= nv_cnt - 32'd1;
        if (nv_cnt == 32'd1) begin
          nv_busy <= 1'b0;
        end
      end
      if (vol_go) begin
        vol_cnt <= 8'(VO_CYC);
        pend    <= merge_status(sr, wr_word, wr_long, 1'b1);
      end else if (vol_cnt != 8'd0) begin
        vol_cnt <= vol_cnt - 8'd1;
      end
    end
  end

  // stored status bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr <= `STAT_RESET;
    end else if (nv_done || vol_cnt == 8'd1) begin
      sr <= pend;
    end
  end

  assign busy      = nv_busy | ext_cycle_busy;
  assign stat_word = {suspended_in, sr[14:11], 1'b0, sr[9:2],
                      write_latch_flag, busy};
  assign status    = status_s'(stat_word);

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cmd_end(logic [7:0] op);
    cs_rise && state == ST_SKIP && clk_cnt == 5'd0 && cmd == op;
  endsequence

  sequence s_busy_opcode;
    rise && state == ST_OPCODE && clk_cnt == 5'd7 && busy &&
    next_sh[7:0] != `OP_STAT1_RD && next_sh[7:0] != `OP_STAT2_RD;
  endsequence

  AST_LATCH_SET: assert property (s_cmd_end(`OP_LATCH_SET)
    |=> write_latch_flag)
    else $error("latch not set");
  AST_VOL_KEEP: assert property (s_cmd_end(`OP_VOL_ENABLE)
    ##0 !ext_cycle_done
    |=> vol_en && write_latch_flag == $past(write_latch_flag))
    else $error("volatile enable disturbed latch");
  AST_LATCH_CLR: assert property (s_cmd_end(`OP_LATCH_CLR)
    |=> !write_latch_flag && !vol_en)
    else $error("latch clear failed");
  AST_NV_START: assert property (nv_go
    |=> nv_busy && status.busy && nv_cnt == 32'(NV_CYC))
    else $error("write cycle not started");
  AST_NV_DONE: assert property (nv_done
    |=> !nv_busy && !write_latch_flag && sr == $past(pend))
    else $error("write cycle end wrong");
  AST_NEED_LATCH: assert property (wr_end && !write_latch_flag
    |=> !nv_busy)
    else $error("write without latch");
  AST_BAD_LEN: assert property (cs_rise && state == ST_WDATA &&
    !(clk_cnt == `WR_SHORT || clk_cnt == `WR_LONG)
    |=> !nv_busy && vol_cnt == 8'd0)
    else $error("odd-length write acted");
  AST_OTP: assert property (
    ($past(sr[13:11]) & ~sr[13:11]) == 3'b000)
    else $error("lock bit cleared");
  AST_VOL_QUIET: assert property (vol_go
    |=> !nv_busy && !write_latch_flag ##1 sr == $past(pend))
    else $error("volatile refresh wrong");
  AST_BUSY_SKIP: assert property (s_busy_opcode
    |=> state == ST_SKIP)
    else $error("busy command accepted");
  AST_CS_CLEAR: assert property (cs_f
    |=> state == ST_OPCODE && clk_cnt == 5'd0)
    else $error("deselect did not clear");
  AST_STREAM: assert property (req_fire && !cs_f && !rd_start
    |=> rd_addr == $past(rd_addr) + 24'd1)
    else $error("read address not advanced");

endmodule // serial_flash_cmd

// ==== flash_cmd_params.svh ====
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH
// instruction codes
`define OP_LATCH_SET  8'h06
`define OP_VOL_ENABLE 8'h50
`define OP_LATCH_CLR  8'h04
`define OP_STAT1_RD   8'h05
`define OP_STAT2_RD   8'h35
`define OP_STAT_WR    8'h01
`define OP_ARRAY_RD   8'h03
`define OP_ID_RD      8'hab
`define OP_ID2_RD     8'h92
`define OP_ID4_RD     8'h94
// status word: writable bits, reset value, field positions
`define STAT_WR_MASK  16'h7bfc
`define STAT_RESET    16'h0000
`define POS_FOUR_LINE 9
`define POS_PROT_COMP 14
`define POS_LOCK1     8
// phase lengths in link clocks
`define ADDR_CLKS_1   5'd24
`define ADDR_CLKS_2   5'd16
`define ADDR_CLKS_4   5'd8
`define DUMMY_CLKS_4  5'd4
`define WR_SHORT      5'd8
`define WR_LONG       5'd16
// timing
`define CORE_PERIOD_NS     100
`define STAT_WRITE_TIME_NS 10000000
`define VOL_REFRESH_NS     50
`endif

// ==== flash_cmd_pkg.sv ====
package flash_cmd_pkg;
  // status registers 2 and 1, msb first
  typedef struct packed {
    logic       suspended_flag;
    logic       protect_complement;
    logic [2:0] security_lock_bits;
    logic       reserved;
    logic       four_line_enable;
    logic       status_lock_bit1;
    logic       status_lock_bit0;
    logic       sector_granularity_select;
    logic       top_bottom_select;
    logic [2:0] block_protect_field;
    logic       write_latch_flag;
    logic       busy;
  } status_s;

  typedef enum logic [5:0] {
    ST_OPCODE = 6'b000001,
    ST_ADDR   = 6'b000010,
    ST_DUMMY  = 6'b000100,
    ST_WDATA  = 6'b001000,
    ST_OUT    = 6'b010000,
    ST_SKIP   = 6'b100000
  } phase_e;

  typedef logic [2:0] lanes_t;
endpackage

// ==== spi_host.sv ====
`timescale 1ns/10ps
module spi_host (
  input  wire logic       core_clk,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n,
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic [3:0]      io_in
);
  // idle: deselected, clock parked low
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    io_in    = 4'h0;
  end
  // one link clock: lanes set, rise, sample just before the fall
  task automatic bit_clk(input logic [3:0] v, output logic [3:0] q);
    @(negedge core_clk);
    io_in = v;
    repeat (4) @(negedge core_clk);
    sclk_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    q = io_out ^ io_oe_n; // undriven lanes read inverted
    sclk_pin = 1'b0;
  endtask
  // open a frame after the deselect gap
  task automatic sel();
    repeat (4) @(negedge core_clk);
    cs_n_pin = 1'b0;
  endtask
  // close a frame; released lanes flip so stale levels never pass
  task automatic desel();
    @(negedge core_clk);
    cs_n_pin = 1'b1;
    io_in    = ~io_in;
    repeat (6) @(negedge core_clk);
  endtask
  // byte msb first over 1, 2 or 4 lanes
  task automatic send(input logic [7:0] b, input int w);
    logic [3:0] q;
    for (int i = 8 - w; i >= 0; i -= w) begin
      bit_clk(4'((b >> i) & ((1 << w) - 1)), q);
    end
  endtask
  // byte msb first from 1, 2 or 4 lanes; own lanes toggle meanwhile
  task automatic recv(input int w, output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      bit_clk(~io_in, q);
      if (w == 1) b = {b[6:0], q[1]};
      else if (w == 2) b = {b[5:0], q[1:0]};
      else b = {b[3:0], q};
    end
  endtask
endmodule // spi_host

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import flash_cmd_pkg::*;
  localparam logic [7:0] MF = 8'ha5; // arbitrary value
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic        core_clk, rst_n, cs_n_pin, sclk_pin;
  logic [3:0]  io_in, io_out, io_oe_n;
  logic        ext_cycle_busy, ext_cycle_done, suspended_in;
  logic        req_valid, req_ready, mem_ready;
  logic [23:0] req_addr;
  logic        mem_valid = 1'b0;
  logic [7:0]  mem_data  = 8'h00;
  logic        req_hs    = 1'b0;
  logic [7:0]  req_a     = 8'h00;
  status_s     status;
  int          n_errors  = 0;
  int          checks    = 0;

  serial_flash_cmd #(.STAT_WRITE_TIME_NS(2000), .MANUF_ID(MF),
    .DEVICE_ID(ID)) serial_flash_cmd_i (.core_clk(core_clk), .rst_n(rst_n),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .ext_cycle_busy(ext_cycle_busy),
    .ext_cycle_done(ext_cycle_done), .suspended_in(suspended_in),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_data(mem_data),
    .status(status));
  spi_host spi_host_i (.core_clk(core_clk), .io_out(io_out),
    .io_oe_n(io_oe_n),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_in(io_in));

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // array model: answers each taken fetch one cycle later
  always @(posedge core_clk) begin
    req_hs <= req_valid & req_ready;
    req_a  <= req_addr[7:0];
  end
  always @(negedge core_clk) begin
    mem_valid <= req_hs;
    mem_data  <= req_a ^ 8'h5a;
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // single-byte instruction frame
  task automatic op1(input logic [7:0] op);
    spi_host_i.sel();
    spi_host_i.send(op, 1);
    spi_host_i.desel();
  endtask
  // status read, two bytes of the repeating stream
  task automatic rd(input logic [7:0] op, output logic [7:0] a, b);
    spi_host_i.sel();
    spi_host_i.send(op, 1);
    spi_host_i.recv(1, a);
    spi_host_i.recv(1, b);
    spi_host_i.desel();
  endtask
  // status write of nb data clocks, low byte first
  task automatic wrs(input logic [15:0] d, input int nb);
    logic [3:0] q;
    spi_host_i.sel();
    spi_host_i.send(8'h01, 1);
    for (int i = 0; i < nb; i++) begin
      spi_host_i.bit_clk({3'b000, d[(i < 8) ? 7 - i : 23 - i]}, q);
    end
    spi_host_i.desel();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (status.busy !== 1'b0 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 500) begin
      n_errors++;
      $display("[ERR] busy expected 0 seen 1");
      results();
    end
  endtask

  task automatic t_latch();
    logic [7:0] a, b;
    logic [3:0] q;
    chk("reset status", 16'h0000, status);
    op1(8'h06);
    chk("latch set", 16'h0002, status);
    rd(8'h05, a, b);
    chk("sr1 stream", 16'h0202, {a, b});
    op1(8'h04);
    chk("latch clear", 16'h0000, status);
    spi_host_i.sel();
    spi_host_i.send(8'h06, 1);
    spi_host_i.bit_clk(4'h0, q);
    spi_host_i.desel();
    chk("nine clocks", 16'h0000, status);
    op1(8'h06);
    @(negedge core_clk) ext_cycle_done = 1'b1;
    @(negedge core_clk) ext_cycle_done = 1'b0;
    chk("done clears", 16'h0000, status);
    ext_cycle_busy = 1'b1;
    op1(8'h06);
    chk("busy blocks", 16'h0001, status);
    rd(8'h05, a, b);
    chk("busy read", 16'h0101, {a, b});
    ext_cycle_busy = 1'b0;
    $display("test latch done");
  endtask

  task automatic t_nv();
    op1(8'h06);
    wrs(16'hffff, 16);
    chk("nv busy", 16'h0003, status & 16'h0003);
    wait_idle();
    chk("nv full", 16'h7bfc, status);
    wrs(16'h0000, 16);
    chk("no latch", 16'h7bfc, status);
    op1(8'h06);
    wrs(16'h0000, 8);
    wait_idle();
    chk("nv short", 16'h3900, status);
    op1(8'h06);
    wrs(16'h0000, 16);
    wait_idle();
    chk("locks stay", 16'h3800, status);
    $display("test nv done");
  endtask

  task automatic t_vol();
    op1(8'h50);
    chk("arm only", 16'h3800, status);
    wrs(16'h00fc, 16);
    for (int i = 0; i < 3; i++) begin
      chk("vol busy", 16'h0000, status & 16'h0001);
      @(negedge core_clk);
    end
    chk("vol write", 16'h38fc, status);
    op1(8'h06);
    wrs(16'h0000, 12);
    chk("twelve bits", 16'h38fe, status);
    op1(8'h04);
    op1(8'h50);
    op1(8'h04);
    wrs(16'h0000, 16);
    chk("arm cancel", 16'h38fc, status);
    $display("test vol done");
  endtask

  task automatic t_array();
    logic [7:0] b, e;
    for (int k = 0; k < 2; k++) begin
      ext_cycle_busy = (k == 1);
      spi_host_i.sel();
      spi_host_i.send(8'h03, 1);
      spi_host_i.send(8'h00, 1);
      spi_host_i.send(8'h00, 1);
      spi_host_i.send(8'hfe, 1);
      for (int i = 0; i < 3; i++) begin
        spi_host_i.recv(1, b);
        e = 8'(8'hfe + i) ^ 8'h5a;
        if (k == 0) chk("array byte", {8'h00, e}, {8'h00, b});
        else chk("busy oe", 16'h000f, {12'h000, io_oe_n});
      end
      spi_host_i.desel();
    end
    ext_cycle_busy = 1'b0;
    $display("test array done");
  endtask

  task automatic t_ids();
    logic [7:0] b;
    spi_host_i.sel();
    spi_host_i.send(8'hab, 1);
    for (int i = 0; i < 3; i++) spi_host_i.send(8'h00, 1);
    for (int i = 0; i < 2; i++) begin
      spi_host_i.recv(1, b);
      chk("id repeat", {8'h00, ID}, {8'h00, b});
    end
    spi_host_i.desel();
    for (int w = 2; w <= 4; w += 2) begin
      spi_host_i.sel();
      spi_host_i.send((w == 2) ? 8'h92 : 8'h94, 1);
      for (int i = 0; i < ((w == 2) ? 4 : 6); i++) spi_host_i.send(8'h00, w);
      for (int i = 0; i < 3; i++) begin
        spi_host_i.recv(w, b);
        chk("mf id pair", {8'h00, i[0] ? ID : MF}, {8'h00, b});
      end
      spi_host_i.desel();
    end
    $display("test ids done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst_n          = 1'b0;
    ext_cycle_busy = 1'b0;
    ext_cycle_done = 1'b0;
    suspended_in   = 1'b0;
    req_ready      = 1'b1;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    t_latch();
    t_nv();
    t_vol();
    t_array();
    t_ids();
    results();
  end
endmodule // testbench
